/* File: dv/i2c_ctrl_model.sv */
// Bus controller model that drives the serial configuration bus.
`timescale 1ns/1ps

module i2c_ctrl_model (
  // Core clock that paces every bus phase.
  input  wire logic core_clk,
  // Bus clock and data lines.
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // The clock rests driven high; data rests released, so the pull-up holds it high.
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // Waits n falling core edges; one bus phase spans four of them.
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // Sends one bit, changing data only while the clock is low.
  task automatic send_bit(input logic b);
    sda_m = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : send_bit

  // Releases data and samples it in the middle of the high phase.
  task automatic get_bit(output logic b);
    sda_m = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'b0;
  endtask : get_bit

  // Sends a byte, most significant bit first, and takes the ack.
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : byte_out

  // Takes a byte, then acks it, or not when it is the last one.
  task automatic byte_in(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    send_bit(last);
  endtask : byte_in

  // Start condition: data falls while the clock is high.
  task automatic start;
    sda_m = 1'b1;
    scl   = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask : start

  // Stop condition: data rises while the clock is high.
  task automatic stop;
    sda_m = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask : stop

  // Writes both bytes in one transaction, first byte low.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d,
                           output logic ack);
    logic a0, a1, a2;
    start;
    byte_out(a, a0);
    byte_out(d[7:0], a1);
    byte_out(d[15:8], a2);
    stop;
    ack = a0 & a1 & a2;
  endtask : write_reg

  // Reads one or two bytes, first byte into the low half.
  task automatic read_reg(input logic [7:0] a, input logic two,
                          output logic [15:0] d, output logic ack);
    d = 16'h0000;
    start;
    byte_out(a | 8'h01, ack);
    byte_in(~two, d[7:0]);
    if (two)
      byte_in(1'b1, d[15:8]);
    stop;
  endtask : read_reg
endmodule : i2c_ctrl_model

/* File: dv/tb_top.sv */
// Self-checking bench for the channel lane configuration registers.
`timescale 1ns/1ps
`include "channel_lane_config_consts.svh"

module tb_top;
  logic                                core_clk;  // Core clock.
  logic                                rst_b;     // Reset, active low.
  logic                                scl;       // Bus clock.
  logic                                sda_m;     // Controller data drive.
  logic                                sda_out;   // Device data value.
  logic                                sda_oe;    // Device pulls low.
  wire                                 sda;       // Resolved data wire.
  channel_lane_config_pkg::chan_ctrl_t ctrl;      // Decoded controls.
  logic [31:0]                         chan_in;   // Channel lanes in.
  logic [31:0]                         chan_out;  // Channel lanes out.
  logic [3:0]                          chan_oe;   // Lane drive enables.
  logic [31:0]                         logic_out_data;
  logic [31:0]                         logic_in_data;
  int                                  failures;
  int                                  num_checks;
  int                                  seed;
  int                                  mdl [2];   // Register model.

  // Open drain data wire with a pull-up.
  assign sda = sda_m & ~(sda_oe & ~sda_out);

  channel_lane_config_regs u_channel_lane_config_regs (
    .core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl), .chan_in(chan_in),
    .chan_out(chan_out), .chan_oe(chan_oe),
    .logic_out_data(logic_out_data), .logic_in_data(logic_in_data)
  );

  i2c_ctrl_model u_i2c_ctrl_model (
    .core_clk(core_clk), .scl(scl), .sda_m(sda_m), .sda(sda)
  );

  // Clock of 50 ns period.
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Bus address of register bank i.
  function automatic logic [7:0] dev_addr(input int i);
    return (i == 0) ? `DEV0_ADDR : `DEV1_ADDR;
  endfunction : dev_addr

  // Expected control word built from the model.
  function automatic logic [31:0] exp_ctrl();
    logic [15:0] r0, r1;
    r0 = mdl[0][15:0];
    r1 = mdl[1][15:0];
    return {r0[7:4], r0[3:0], r0[15:12], r0[11:8],
            r1[15], r1[14], r1[7], r1[6], r1[5:0], r1[13:8]};
  endfunction : exp_ctrl

  // Holds reset for 16 cycles and resets the model.
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    mdl[0] = 'hffff;
    mdl[1] = 'hffff;
    check(ctrl, 32'hffffffff);
  endtask : do_reset

  // Reads back both banks in two-byte and one-byte form.
  task automatic check_regs;
    logic [15:0] d;
    logic        ak;
    for (int i = 0; i < 2; i++)
    begin
      u_i2c_ctrl_model.read_reg(dev_addr(i), 1'b1, d, ak);
      check({31'h0, ak}, 32'h1);
      check({16'h0, d}, mdl[i]);
      u_i2c_ctrl_model.read_reg(dev_addr(i), 1'b0, d, ak);
      check({16'h0, d}, mdl[i] & 'hff);
    end
    check(ctrl, exp_ctrl());
  endtask : check_regs

  // Random lane traffic, compared one cycle later.
  task automatic lane_burst;
    logic [31:0] ci, lo, ei;
    for (int k = 0; k < 4; k++)
    begin
      ci = $random(seed);
      lo = $random(seed);
      chan_in = ci;
      logic_out_data = lo;
      @(negedge core_clk);
      for (int g = 0; g < 4; g++)
        ei[g*8+:8] = mdl[0][4+g] ? 8'h00 : ci[g*8+:8];
      check(logic_in_data, ei);
      check(chan_out, lo);
      check({28'h0, chan_oe}, {28'h0, ~mdl[0][3:0]});
    end
  endtask : lane_burst

  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    final_report;
  end

  // Main sequence.
  initial
  begin
    logic [15:0] w;
    logic        ak;
    int          i;
    seed = 32'h044330ea;
    failures = 0;
    num_checks = 0;
    rst_b = 1'b0;
    chan_in = 32'h0;
    logic_out_data = 32'h0;
    do_reset;
    check_regs;
    lane_burst;
    $display("Test reset defaults done");
    // Boundary values first, then random ones.
    for (int k = 0; k < 8; k++)
    begin
      i = k % 2;
      w = (k < 2) ? ((i == 0) ? 16'h000f : 16'h0000) : 16'($random(seed));
      if (i == 0)
        w[7:4] = w[7:4] | ~w[3:0];
      u_i2c_ctrl_model.write_reg(dev_addr(i), w, ak);
      check({31'h0, ak}, 32'h1);
      mdl[i] = w;
      check_regs;
      lane_burst;
    end
    $display("Test write and readback done");
    // A foreign address is not acknowledged and changes nothing.
    u_i2c_ctrl_model.write_reg(8'h44, 16'h1234, ak);
    check({31'h0, ak}, 32'h0);
    check_regs;
    $display("Test foreign address done");
    do_reset;
    check_regs;
    lane_burst;
    $display("Test second reset done");
    final_report;
  end
endmodule : tb_top

/* File: hw/channel_lane_config_regs.sv */
// Two serial-bus configuration targets that steer a 32-bit byte-lane channel.
`timescale 1ns/1ps
`include "channel_lane_config_consts.svh"

module channel_lane_config_regs #(
  parameter int LANES = 4
) (
  // Clock and reset.
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_b,
  // Serial configuration bus, open drain data line.
  input  wire logic                                 scl,
  input  wire logic                                 sda_in,
  output logic                                      sda_out,
  output logic                                      sda_oe,
  // Decoded control bits.
  output channel_lane_config_pkg::chan_ctrl_t       ctrl,
  // Channel byte lanes.
  input  wire logic [LANES*`LANE_BITS-1:0]          chan_in,
  output logic      [LANES*`LANE_BITS-1:0]          chan_out,
  output logic      [LANES-1:0]                     chan_oe,
  // Logic-side data words.
  input  wire logic [LANES*`LANE_BITS-1:0]          logic_out_data,
  output logic      [LANES*`LANE_BITS-1:0]          logic_in_data
);

  // Protocol state and its next value.
  channel_lane_config_pkg::bus_state_t state_q, state_d;
  logic        scl_q;      // Previous clock line sample.
  logic        sda_q;      // Previous data line sample.
  logic [2:0]  bit_q;      // Bit position within the byte.
  logic [2:0]  bit_d;
  logic [7:0]  shift_q;    // Byte being shifted in or out.
  logic [7:0]  shift_d;
  logic [7:0]  hold_q;     // First written byte awaiting the second.
  logic [7:0]  hold_d;
  logic        dev_q;      // Selected target: 0 for 0x40, 1 for 0x42.
  logic        dev_d;
  logic        byte_q;     // Byte index within the transaction.
  logic        byte_d;
  logic        ackd_q;     // Acknowledge low is being driven.
  logic        ackd_d;
  logic        oe_q;       // Data line pull-down.
  logic        oe_d;
  logic [15:0] reg0_q;     // Lane direction and clock select.
  logic [15:0] reg0_d;
  logic [15:0] reg1_q;     // Termination and auxiliary enables.
  logic [15:0] reg1_d;
  logic        commit;     // Second write byte completed.

  // Bus line events, taken from one-cycle-old samples.
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] addr_byte;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda_in;
  assign stop_ev  = scl & scl_q & ~sda_q & sda_in;
  assign in_byte  = {shift_q[6:0], sda_in};
  assign addr_byte = {in_byte[7:1], 1'b0};
  // Read data: first byte is the low half, second the high half.
  assign rd_byte = byte_q ? (dev_q ? reg1_q[15:8] : reg0_q[15:8])
                          : (dev_q ? reg1_q[7:0]  : reg0_q[7:0]);

  // Next-state logic of the bus engine and the register file.
  always_comb
  begin
    state_d = state_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    hold_d  = hold_q;
    dev_d   = dev_q;
    byte_d  = byte_q;
    ackd_d  = ackd_q;
    oe_d    = oe_q;
    reg0_d  = reg0_q;
    reg1_d  = reg1_q;
    commit  = 1'b0;
    if (start_ev)
    begin
      // A start, repeated or not, always begins a new address byte.
      state_d = channel_lane_config_pkg::ST_ADDR;
      bit_d   = 3'h0;
      oe_d    = 1'b0;
      ackd_d  = 1'b0;
    end
    else if (stop_ev)
    begin
      // A stop abandons any half-written pair.
      state_d = channel_lane_config_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end
    else
    begin
      unique case (state_q)
        channel_lane_config_pkg::ST_IDLE:
        begin
          oe_d = 1'b0;
        end
        channel_lane_config_pkg::ST_ADDR:
        begin
          if (scl_rise)
          begin
            shift_d = in_byte;
            bit_d   = bit_q + 3'h1;
            if (bit_q == `LAST_BIT)
            begin
              // Only the two target addresses are answered.
              if (addr_byte == `DEV0_ADDR || addr_byte == `DEV1_ADDR)
              begin
                dev_d   = (addr_byte == `DEV1_ADDR);
                byte_d  = 1'b0;
                state_d = channel_lane_config_pkg::ST_ADDR_AK;
              end
              else
              begin
                state_d = channel_lane_config_pkg::ST_IDLE;
              end
            end
          end
        end
        channel_lane_config_pkg::ST_ADDR_AK,
        channel_lane_config_pkg::ST_WR_AK:
        begin
          // Pull low for one whole clock-high period, then let go.
          if (scl_fall && !ackd_q)
          begin
            ackd_d = 1'b1;
            oe_d   = 1'b1;
          end
          else if (scl_fall)
          begin
            ackd_d = 1'b0;
            oe_d   = 1'b0;
            bit_d  = 3'h0;
            if (state_q == channel_lane_config_pkg::ST_ADDR_AK && shift_q[0])
            begin
              // Read: the first data bit goes out on this same edge.
              state_d = channel_lane_config_pkg::ST_RD;
              oe_d    = ~rd_byte[7];
              shift_d = {rd_byte[6:0], 1'b0};
              byte_d  = ~byte_q;
            end
            else
            begin
              state_d = channel_lane_config_pkg::ST_WR;
            end
          end
        end
        channel_lane_config_pkg::ST_WR:
        begin
          if (scl_rise)
          begin
            shift_d = in_byte;
            bit_d   = bit_q + 3'h1;
            if (bit_q == `LAST_BIT)
            begin
              state_d = channel_lane_config_pkg::ST_WR_AK;
              byte_d  = ~byte_q;
              if (!byte_q)
              begin
                hold_d = in_byte;
              end
              else
              begin
                // Both bytes update together, never one alone.
                commit = 1'b1;
                if (dev_q)
                begin
                  reg1_d = {in_byte, hold_q};
                end
                else
                begin
                  reg0_d = {in_byte, hold_q};
                end
              end
            end
          end
        end
        channel_lane_config_pkg::ST_RD:
        begin
          if (scl_rise)
          begin
            bit_d = bit_q + 3'h1;
            if (bit_q == `LAST_BIT)
            begin
              state_d = channel_lane_config_pkg::ST_RD_AK;
            end
          end
          else if (scl_fall)
          begin
            oe_d    = ~shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
          end
        end
        channel_lane_config_pkg::ST_RD_AK:
        begin
          // Release the line so the master can answer.
          if (scl_fall)
          begin
            oe_d = 1'b0;
          end
          else if (scl_rise)
          begin
            state_d = sda_in ? channel_lane_config_pkg::ST_IDLE
                             : channel_lane_config_pkg::ST_RD_NEXT;
          end
        end
        channel_lane_config_pkg::ST_RD_NEXT:
        begin
          // Master acknowledged: present the next byte in order.
          if (scl_fall)
          begin
            state_d = channel_lane_config_pkg::ST_RD;
            bit_d   = 3'h0;
            oe_d    = ~rd_byte[7];
            shift_d = {rd_byte[6:0], 1'b0};
            byte_d  = ~byte_q;
          end
        end
      endcase
    end
  end

  // Registers of the bus engine; control bits come up at all ones.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q <= channel_lane_config_pkg::ST_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      hold_q  <= 8'hff;
      dev_q   <= 1'b0;
      byte_q  <= 1'b0;
      ackd_q  <= 1'b0;
      oe_q    <= 1'b0;
      reg0_q  <= `REG_RESET_VAL;
      reg1_q  <= `REG_RESET_VAL;
    end
    else
    begin
      state_q <= state_d;
      scl_q   <= scl;
      sda_q   <= sda_in;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      hold_q  <= hold_d;
      dev_q   <= dev_d;
      byte_q  <= byte_d;
      ackd_q  <= ackd_d;
      oe_q    <= oe_d;
      reg0_q  <= reg0_d;
      reg1_q  <= reg1_d;
    end
  end

  // The data line is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // Control field decode.
  always_comb
  begin
    ctrl.input_en_n       = reg0_q[`R0_IN_EN];
    ctrl.output_en_n      = reg0_q[`R0_OUT_EN];
    ctrl.clk_sel_video_n  = reg0_q[`R0_VIDEO_SEL];
    ctrl.clk_sel_ext_n    = reg0_q[`R0_EXT_SEL];
    ctrl.termination_en_n = {reg1_q[`R1_TERM_DC], reg1_q[`R1_TERM_BA]};
    ctrl.aux_output_en_n  = reg1_q[`R1_AUX_OUT];
    ctrl.aux_input_en_n   = reg1_q[`R1_AUX_IN];
  end

  // Per-lane data path, one word registered per clock in each direction.
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      logic [`LANE_BITS-1:0] out_d;
      logic [`LANE_BITS-1:0] in_d;
      logic                  oe_lane_d;
      logic [`LANE_BITS-1:0] out_q;
      logic [`LANE_BITS-1:0] in_q;
      logic                  oe_lane_q;

      // Lane steering from the direction bits.
      always_comb
      begin
        oe_lane_d = ~reg0_q[g];
        out_d     = logic_out_data[g*`LANE_BITS +: `LANE_BITS];
        in_d      = reg0_q[g+LANES] ? '0
                    : chan_in[g*`LANE_BITS +: `LANE_BITS];
      end

      // Lane output registers.
      always_ff @(posedge core_clk)
      begin
        if (!rst_b)
        begin
          out_q     <= '0;
          in_q      <= '0;
          oe_lane_q <= 1'b0;
        end
        else
        begin
          out_q     <= out_d;
          in_q      <= in_d;
          oe_lane_q <= oe_lane_d;
        end
      end

      assign chan_out[g*`LANE_BITS +: `LANE_BITS]      = out_q;
      assign logic_in_data[g*`LANE_BITS +: `LANE_BITS] = in_q;
      assign chan_oe[g]                                = oe_lane_q;
    end
  endgenerate

  // Checks on the bus engine and lane steering.
  sequence s_start;
    scl && $past(scl) && $past(sda_in) && !sda_in;
  endsequence

  a_reset_ones: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> reg0_q == 16'hffff && reg1_q == 16'hffff)
    else $error("Control bits not at one after reset.");
  a_start_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_start |=> state_q == channel_lane_config_pkg::ST_ADDR && !sda_oe)
    else $error("Start did not open an address byte.");
  a_pair_commit: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(reg0_q) |-> $past(state_q) == channel_lane_config_pkg::ST_WR
      && $past(byte_q) && !$past(dev_q))
    else $error("Register changed outside a paired write.");
  a_commit_dev1: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(reg1_q) |-> $past(commit) && $past(dev_q))
    else $error("Second target changed without a commit.");
  a_nack_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == channel_lane_config_pkg::ST_RD_AK && scl_rise && sda_in
      && !start_ev && !stop_ev |=> state_q == channel_lane_config_pkg::ST_IDLE)
    else $error("Read did not end on master refusal.");
  a_lane_oe: assert property (@(posedge core_clk) disable iff (!rst_b)
    !$rose(rst_b) |-> chan_oe == ~$past(reg0_q[3:0]))
    else $error("Lane drive does not follow its enable.");
  a_lane_in: assert property (@(posedge core_clk) disable iff (!rst_b)
    !$rose(rst_b) && $past(reg0_q[4]) |-> logic_in_data[7:0] == 8'h00)
    else $error("Disabled input lane passed data.");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    stop_ev && !start_ev |=> state_q == channel_lane_config_pkg::ST_IDLE
      && !sda_oe)
    else $error("Stop did not release the bus.");
  a_term_map: assert property (@(posedge core_clk) disable iff (!rst_b)
    ctrl.termination_en_n == {reg1_q[15:14], reg1_q[7:6]})
    else $error("Termination bits misplaced.");

endmodule : channel_lane_config_regs

/* File: include/channel_lane_config_consts.svh */
// Constant definitions for the channel lane configuration register bank.
`ifndef CHANNEL_LANE_CONFIG_CONSTS_SVH
`define CHANNEL_LANE_CONFIG_CONSTS_SVH

// Bus addresses of the two targets, write form with the direction bit at 0.
`define DEV0_ADDR       8'h40
`define DEV1_ADDR       8'h42
// Power-up value of every control register.
`define REG_RESET_VAL   16'hffff
// Index of the last bit in a byte.
`define LAST_BIT        3'h7
// Field positions in the lane direction and clock select register.
`define R0_IN_EN        7:4
`define R0_OUT_EN       3:0
`define R0_VIDEO_SEL    15:12
`define R0_EXT_SEL      11:8
// Field positions in the termination and auxiliary enable register.
`define R1_TERM_BA      7:6
`define R1_TERM_DC      15:14
`define R1_AUX_OUT      5:0
`define R1_AUX_IN       13:8
// Byte lane geometry of the channel data path.
`define LANE_BITS       8

`endif

/* File: include/channel_lane_config_pkg.sv */
// Types shared by the channel lane configuration register bank.
package channel_lane_config_pkg;

  // Bus-facing protocol states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDR_AK = 3'b010,
    ST_WR      = 3'b011,
    ST_WR_AK   = 3'b100,
    ST_RD      = 3'b101,
    ST_RD_AK   = 3'b110,
    ST_RD_NEXT = 3'b111
  } bus_state_t;

  // Decoded control bits; all active low, index 3..0 is lane D..A.
  typedef struct packed {
    logic [3:0] input_en_n;
    logic [3:0] output_en_n;
    logic [3:0] clk_sel_video_n;
    logic [3:0] clk_sel_ext_n;
    logic [3:0] termination_en_n;
    logic [5:0] aux_output_en_n;
    logic [5:0] aux_input_en_n;
  } chan_ctrl_t;

endpackage : channel_lane_config_pkg
